// File: hdl/haptic_loop_defs.svh
/*
 * Offsets, field positions, reset value and lookup constants for the
 * closed-loop feedback configuration register.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef HAPTIC_LOOP_DEFS_SVH
`define HAPTIC_LOOP_DEFS_SVH

// ============================================================
// register map
`define LOOP_CTRL_ADDR      8'h23
`define LOOP_CTRL_RESET     8'h36

// ============================================================
// field positions
`define GATE_BIT            7
`define BRAKE_MSB           6
`define BRAKE_LSB           4
`define SETTLE_MSB          3
`define SETTLE_LSB          2
`define BEMF_MSB            1
`define BEMF_LSB            0

// ============================================================
// noise gate, full scale 8'hFF equals supply
`define GATE_LOW_PCT        4
`define GATE_HIGH_PCT       8
// 4 % and 8 % of 255, rounded down
`define GATE_LOW_LEVEL      8'h0A
`define GATE_HIGH_LEVEL     8'h14

// ============================================================
// brake code that removes braking feedback
`define BRAKE_OFF_CODE      3'h7

// back-emf gain in hundredths, resonant then rotating-mass
`define RES_GAIN_0          12'h1F4
`define RES_GAIN_1          12'h3E8
`define RES_GAIN_2          12'h7D0
`define RES_GAIN_3          12'hBB8
`define ROT_GAIN_0          12'h022
`define ROT_GAIN_1          12'h069
`define ROT_GAIN_2          12'h0B6
`define ROT_GAIN_3          12'h190

`endif

// File: hdl/haptic_loop_pkg.sv
/*
 * Types for the closed-loop feedback configuration register.
 * Assumes haptic_loop_defs.svh supplies the numeric constants.
 */
package haptic_loop_pkg;

	// settling speed, slowest first
	typedef enum logic [1:0]
	{
		SETTLE_VERY_SLOW = 2'h0,
		SETTLE_SLOW      = 2'h1,
		SETTLE_FAST      = 2'h2,
		SETTLE_VERY_FAST = 2'h3
	} settle_speed_t;

	// register image, bit 7 down to bit 0
	typedef struct packed
	{
		logic          output_gate_level;
		logic [2:0]    brake_gain_ratio;
		settle_speed_t feedback_settle_speed;
		logic [1:0]    backemf_amp_gain;
	} loop_cfg_t;

	// decoded controls handed to the loop
	typedef struct packed
	{
		logic          brake_fb_en;
		logic [4:0]    brake_ratio;
		logic [3:0]    settle_weight;
		logic [11:0]   backemf_amp_gain_x100;
	} loop_ctl_t;

endpackage

// File: hdl/haptic_feedback_loop_config.sv
/*
 * Feedback loop configuration register with its decoded controls and the
 * output noise gate.
 * Assumes a byte-wide register port from the serial interface logic and a
 * calibration engine that posts its back-emf gain choice as a strobe.
 */
`timescale 1ns/1ps
`include "haptic_loop_defs.svh"

// Summary of operation
// - Drive magnitudes below 4 % (gate bit 0) or 8 % (gate bit 1) of supply come out as zero.
// - Brake codes 0 to 6 give braking-to-driving gain ratios 1, 2, 3, 4, 6, 8 and 16.
// - Brake code 7 removes braking feedback while braking.
// - Settling code 0 is very slow and code 1 is slow.
// - A higher settling code always settles faster than a lower one.
// - The two low bits pick the back-emf amplifier gain, read per actuator type.
// - Gain codes 0 to 3 mean 5x/10x/20x/30x resonant and 0.34x/1.05x/1.82x/4x rotating.
// - Calibration loads the gain field and a later host write still overrides it.
module haptic_feedback_loop_config
	import haptic_loop_pkg::*;
(
	// clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_sys_rst,
	// register port
	input  wire logic [7:0]  i_reg_addr,
	input  wire logic        i_reg_wr,
	input  wire logic        i_reg_rd,
	input  wire logic [7:0]  i_reg_wdata,
	output logic      [7:0]  o_reg_rdata,
	// calibration result
	input  wire logic        i_cal_gain_wr,
	input  wire logic [1:0]  i_cal_gain,
	// actuator and drive path
	input  wire logic        i_rotating_mass_actuator,
	input  wire logic        i_braking,
	input  wire logic [7:0]  i_drive_mag,
	output logic      [7:0]  o_drive_mag,
	// decoded loop controls
	output loop_ctl_t        o_loop_ctl,
	output logic      [1:0]  o_settle_speed
);

	// ============================================================
	// lookups
	function automatic logic [4:0] brake_ratio_of(input logic [2:0] code);
		logic [4:0] r;
		r = 5'h00;
		case (code)
			3'h0: r = 5'h01;
			3'h1: r = 5'h02;
			3'h2: r = 5'h03;
			3'h3: r = 5'h04;
			3'h4: r = 5'h06;
			3'h5: r = 5'h08;
			3'h6: r = 5'h10;
			default: r = 5'h00;
		endcase
		return r;
	endfunction

	function automatic logic [11:0] res_gain_of(input logic [1:0] code);
		logic [11:0] g;
		g = 12'h000;
		case (code)
			2'h0: g = `RES_GAIN_0;
			2'h1: g = `RES_GAIN_1;
			2'h2: g = `RES_GAIN_2;
			default: g = `RES_GAIN_3;
		endcase
		return g;
	endfunction

	// rotating-mass gain sits below unity at code 0 only
	function automatic logic [11:0] rot_gain_of(input logic [1:0] code);
		logic [11:0] g;
		g = 12'h000;
		case (code)
			2'h0: g = `ROT_GAIN_0;
			2'h1: g = `ROT_GAIN_1;
			2'h2: g = `ROT_GAIN_2;
			default: g = `ROT_GAIN_3;
		endcase
		return g;
	endfunction

	// ============================================================
	// register state
	loop_cfg_t cfg;
	loop_cfg_t next_cfg;

	// ============================================================
	// current field views
	wire logic       cur_gate   = cfg.output_gate_level;
	wire logic [2:0] cur_brake  = cfg.brake_gain_ratio;
	wire logic [1:0] cur_settle = cfg.feedback_settle_speed;
	wire logic [1:0] cur_gain   = cfg.backemf_amp_gain;

	// ============================================================
	// register write path
	wire logic hit     = (i_reg_addr == `LOOP_CTRL_ADDR);
	wire logic host_wr = i_reg_wr & hit;
	wire logic host_rd = i_reg_rd;

	// host byte split into its fields
	wire logic       wr_gate   = i_reg_wdata[`GATE_BIT];
	wire logic [2:0] wr_brake  = i_reg_wdata[`BRAKE_MSB:`BRAKE_LSB];
	wire logic [1:0] wr_settle = i_reg_wdata[`SETTLE_MSB:`SETTLE_LSB];
	wire logic [1:0] wr_gain   = i_reg_wdata[`BEMF_MSB:`BEMF_LSB];

	// calibration load, host wins a tie
	wire logic [1:0] next_gain = host_wr ? wr_gain :
	                             i_cal_gain_wr ? i_cal_gain : cur_gain;

	// calibration reads these fields as already set
	wire logic       next_gate   = host_wr ? wr_gate : cur_gate;
	wire logic [2:0] next_brake  = host_wr ? wr_brake : cur_brake;
	wire logic [1:0] next_settle = host_wr ? wr_settle : cur_settle;

	assign next_cfg = loop_cfg_t'({next_gate, next_brake, next_settle, next_gain});

	// ============================================================
	// register storage
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			cfg <= loop_cfg_t'(`LOOP_CTRL_RESET);
		else
			cfg <= next_cfg;
	end

	// ============================================================
	// read path
	// unmapped addresses read as zero
	wire logic [7:0] next_rdata = hit ? cfg : 8'h00;

	// held between strobes so a slow serial side can fetch it later
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_reg_rdata <= 8'h00;
		else if (host_rd)
			o_reg_rdata <= next_rdata;
	end

	// ============================================================
	// noise gate
	// gate threshold select
	wire logic [7:0] gate_level = cur_gate ? `GATE_HIGH_LEVEL : `GATE_LOW_LEVEL;
	wire logic       below_gate = (i_drive_mag < gate_level);
	wire logic [7:0] next_drive = below_gate ? 8'h00 : i_drive_mag;

	// ============================================================
	// braking feedback
	// brake ratio table
	wire logic [4:0] ratio_raw  = brake_ratio_of(cur_brake);
	// no braking feedback on code 7
	wire logic       brake_off  = (cur_brake == `BRAKE_OFF_CODE);
	wire logic       next_fb_en = ~(brake_off & i_braking);
	// ratio forced to zero so the loop never sees a gain with braking off
	wire logic [4:0] next_ratio = brake_off ? 5'h00 : ratio_raw;

	// ============================================================
	// settling speed
	// weight doubles per code, strictly rising
	wire logic [3:0] next_weight     = 4'h1 << cur_settle;
	// raw code copy for logic that wants the setting itself
	wire logic [1:0] next_settle_out = cur_settle;

	// ============================================================
	// back-emf gain
	// gain per actuator type
	wire logic [11:0] res_gain       = res_gain_of(cur_gain);
	wire logic [11:0] rot_gain       = rot_gain_of(cur_gain);
	wire logic [11:0] next_gain_x100 = i_rotating_mass_actuator ? rot_gain : res_gain;

	wire loop_ctl_t next_ctl = '{brake_fb_en:    next_fb_en,
	                             brake_ratio:    next_ratio,
	                             settle_weight:  next_weight,
	                             backemf_amp_gain_x100: next_gain_x100};

	// ============================================================
	// output flops
	// gated drive, one cycle behind the input
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_drive_mag <= 8'h00;
		else
			o_drive_mag <= next_drive;
	end

	// decoded controls, all zero while in reset
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_loop_ctl <= '0;
		else
			o_loop_ctl <= next_ctl;
	end

	// settling code copy
	always_ff @(posedge i_sys_clk or posedge i_sys_rst)
	begin
		if (i_sys_rst)
			o_settle_speed <= 2'h0;
		else
			o_settle_speed <= next_settle_out;
	end

endmodule

// File: dv/haptic_loop_props.sv
/* checker for the feedback loop config register, watching top ports only
   assumes binding to haptic_feedback_loop_config and its defs header */
`timescale 1ns/1ps
`include "haptic_loop_defs.svh"
// ==========
// port checker
module haptic_loop_props
	import haptic_loop_pkg::*;
(
	input wire logic       i_sys_clk, i_sys_rst, i_reg_wr, i_reg_rd, i_cal_gain_wr,
	input wire logic       i_rotating_mass_actuator, i_braking,
	input wire logic [7:0] i_reg_addr, i_reg_wdata, i_drive_mag, o_reg_rdata, o_drive_mag,
	input wire logic [1:0] i_cal_gain, o_settle_speed,
	input wire loop_ctl_t  o_loop_ctl
);
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);
	wire w23 = i_reg_wr && i_reg_addr == `LOOP_CTRL_ADDR;
	localparam logic [4:0]  RT[8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10, 5'h00};
	localparam logic [11:0] GL[4] = '{12'h1F4, 12'h3E8, 12'h7D0, 12'hBB8};
	localparam logic [11:0] GM[4] = '{12'h022, 12'h069, 12'h0B6, 12'h190};
	property p_gate_low;
		!$past(i_sys_rst) && $past(i_drive_mag) < `GATE_LOW_LEVEL |-> o_drive_mag == 8'h00;
	endproperty
	a_gate_low: assert property (p_gate_low) else $error("small input not gated");
	property p_gate_high;
		!$past(i_sys_rst) && $past(i_drive_mag) >= `GATE_HIGH_LEVEL
			|-> o_drive_mag == $past(i_drive_mag);
	endproperty
	a_gate_high: assert property (p_gate_high) else $error("large input altered");
	property p_brake_off;
		!$past(i_sys_rst) |-> o_loop_ctl.brake_fb_en
			== !(o_loop_ctl.brake_ratio == 5'h00 && $past(i_braking));
	endproperty
	a_brake_off: assert property (p_brake_off) else $error("brake feedback wrong");
	property p_brake;
		logic [7:0] d;
		(w23, d = i_reg_wdata) |-> ##2 o_loop_ctl.brake_ratio == RT[d[6:4]];
	endproperty
	a_brake: assert property (p_brake) else $error("brake ratio wrong");
	property p_settle;
		logic [7:0] d;
		(w23, d = i_reg_wdata) |-> ##2 o_settle_speed == d[3:2]
			&& o_loop_ctl.settle_weight == 4'h1 << d[3:2];
	endproperty
	a_settle: assert property (p_settle) else $error("settle speed wrong");
	property p_gain;
		logic [7:0] d;
		(w23, d = i_reg_wdata) |-> ##2 o_loop_ctl.backemf_amp_gain_x100
			== ($past(i_rotating_mass_actuator) ? GM[d[1:0]] : GL[d[1:0]]);
	endproperty
	a_gain: assert property (p_gain) else $error("gain after write wrong");
	property p_cal;
		logic [1:0] g;
		(i_cal_gain_wr && !w23, g = i_cal_gain) |-> ##2 o_loop_ctl.backemf_amp_gain_x100
			== ($past(i_rotating_mass_actuator) ? GM[g] : GL[g]);
	endproperty
	a_cal: assert property (p_cal) else $error("calibration gain wrong");
	property p_rd_unmap;
		i_reg_rd && i_reg_addr != `LOOP_CTRL_ADDR |=> o_reg_rdata == 8'h00;
	endproperty
	a_rd_unmap: assert property (p_rd_unmap) else $error("unmapped read not zero");
	property p_rd_back;
		logic [7:0] d;
		(w23, d = i_reg_wdata) ##1 (i_reg_rd && i_reg_addr == `LOOP_CTRL_ADDR)
			|=> o_reg_rdata == d;
	endproperty
	a_rd_back: assert property (p_rd_back) else $error("read back differs");
endmodule
bind haptic_feedback_loop_config haptic_loop_props props_u (.*);

// File: dv/haptic_feedback_loop_config_tb_top.sv
/* directed bench for the feedback loop config register
   assumes the checker is bound from its own file */
`timescale 1ns/1ps
module haptic_feedback_loop_config_tb_top
	import haptic_loop_pkg::*;
;
	logic       clk = '0, rst = '1, wr = '0, rd = '0, cgw = '0, rot = '0, brk = '0;
	logic [7:0] addr = '0, wd = '0, dm = '0, rdata, odm, v;
	logic [1:0] cg = '0, ss;
	loop_ctl_t  ctl;
	int         num_errors = 0, n_compared = 0;
	logic [4:0]  bt[8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h10, 5'h00};
	logic [11:0] gr[4] = '{12'h1F4, 12'h3E8, 12'h7D0, 12'hBB8};
	always #4 clk = ~clk;
	haptic_feedback_loop_config dut_u (.i_sys_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr),
		.i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdata),
		.i_cal_gain_wr(cgw), .i_cal_gain(cg), .i_rotating_mass_actuator(rot),
		.i_braking(brk), .i_drive_mag(dm), .o_drive_mag(odm), .o_loop_ctl(ctl),
		.o_settle_speed(ss));
	// ==========
	// bus helpers
	task tick; @(posedge clk); #1; endtask
	task chk(input logic [21:0] g, e);
		n_compared++;
		if (g !== e)
		begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task wrr(input logic [7:0] a, d); addr = a; wd = d; wr = 1'b1; tick; wr = 1'b0; endtask
	task rdr(input logic [7:0] a); addr = a; rd = 1'b1; tick; rd = 1'b0; endtask
	task drv(input logic [7:0] i, e); dm = i; tick; chk(odm, e); endtask
	// ==========
	// scenarios
	task t_reset;
		rdr(8'h23);
		chk(rdata, 8'h36);
		chk(ctl, {1'b1, 5'h04, 4'h2, 12'h7D0});
		$display("test reset done");
	endtask
	task t_fields;
		for (int i = 0; i < 8; i++)
		begin
			v = {i[0], i[2:0], i[1:0], i[2:1]};
			wrr(8'h23, v);
			rdr(8'h23);
			chk(rdata, v);
			chk(ss, i[1:0]);
			chk(ctl, {1'b1, bt[i], 4'h1 << i[1:0], gr[i[2:1]]});
		end
		$display("test fields done");
	endtask
	task t_gate;
		wrr(8'h23, 8'h00);
		drv(8'h09, 8'h00);
		drv(8'h0A, 8'h0A);
		wrr(8'h23, 8'h80);
		drv(8'h13, 8'h00);
		drv(8'h14, 8'h14);
		$display("test gate done");
	endtask
	task t_brake;
		wrr(8'h23, 8'h70);
		brk = 1'b1;
		tick;
		chk(ctl[21], 1'b0);
		brk = 1'b0;
		tick;
		chk(ctl[21], 1'b1);
		$display("test brake done");
	endtask
	task t_cal;
		rot = 1'b1;
		wrr(8'h23, 8'h36);
		cgw = 1'b1;
		cg = 2'h1;
		tick;
		cgw = 1'b0;
		tick;
		chk(ctl[11:0], 12'h069);
		rdr(8'h23);
		chk(rdata, 8'h35);
		// host write and calibration on one edge: host data must win
		addr = 8'h23; wd = 8'h36; wr = 1'b1; cgw = 1'b1; cg = 2'h3;
		tick;
		wr = 1'b0;
		cgw = 1'b0;
		rdr(8'h23);
		chk(rdata, 8'h36);
		rot = 1'b0;
		$display("test cal done");
	endtask
	task t_unmapped;
		wrr(8'h24, 8'hFF);
		rdr(8'h24);
		chk(rdata, 8'h00);
		rdr(8'h23);
		chk(rdata, 8'h36);
		$display("test unmapped done");
	endtask
	task results;
		$display("compared %0d, mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial
	begin
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		t_reset; t_fields; t_gate; t_brake; t_cal; t_unmapped;
		results;
	end
	// watchdog, far beyond the roughly 50 cycles the tests need
	initial
	begin
		#20000;
		num_errors++;
		results;
	end
endmodule
